/* core/ucd_dev.sv */
// Controller end: command decoder, endpoint control and outgoing buffer FIFO
`include "ucd_params.svh"

////////////////////////////////////////////////////////////////////////////////
// Shift-register FIFO; head word and flags come straight from flops
module ucd_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = `UCD_FIFO_DEPTH
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [DEPTH-1:0]            vld;
  } ucd_fifo_state_type;

  ucd_fifo_state_type q;
  ucd_fifo_state_type d;

  // Pop shifts everything down, push lands in the first free slot
  always_comb begin
    logic done;
    done = 1'b0;
    d    = q;
    if (q.vld[0] && out_ready) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        d.mem[i] = q.mem[i+1];
        d.vld[i] = q.vld[i+1];
      end
      d.vld[DEPTH-1] = 1'b0;
    end
    if (in_valid && !q.vld[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!done && !d.vld[i]) begin
          d.mem[i] = in_data;
          d.vld[i] = 1'b1;
          done     = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Full is judged on last cycle's state, so ready never depends on a pop
  assign in_ready  = !q.vld[DEPTH-1];
  assign out_valid = q.vld[0];
  assign out_data  = q.mem[0];
endmodule

////////////////////////////////////////////////////////////////////////////////
module ucd_dev #(
  parameter int FIFO_DEPTH = `UCD_FIFO_DEPTH
) (
  input  wire logic                 mclk,
  input  wire logic                 rst,
  ucd_if.dev                        bus,
  input  wire logic [15:0]          ep_dir_in,
  input  wire logic [15:0]          ep_iso,
  input  wire logic [15:0][7:0]     ep_status,
  output logic      [15:0]          dma_byte_counter,
  output logic      [15:0]          ep_stall,
  output logic                      validate_pulse,
  output logic                      clear_pulse,
  output logic                      status_clear_pulse,
  output logic                      dev_reset_pulse,
  output logic      [3:0]           act_ep,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output logic      [15:0]          tx_data,
  output logic      [3:0]           tx_ep,
  output logic                      tx_last,
  input  wire logic                 rx_valid,
  output logic                      rx_ready,
  input  wire logic [15:0]          rx_data,
  output logic      [3:0]           rx_ep
);
  import ucd_pkg::*;

  typedef struct packed {
    ucd_state_type state;
    logic          buf_rd;
    logic [3:0]    ep;
    logic [9:0]    left;
    logic [15:0]   dma;
    logic [15:0]   stall;
    logic          ack;
    logic [15:0]   rdata;
    logic          validate;
    logic          clear;
    logic          stat_clr;
    logic          dev_reset;
    logic [3:0]    act_ep;
    logic          rx_ready;
  } ucd_dev_state_type;

  ucd_dev_state_type q;
  ucd_dev_state_type d;
  logic              push;
  logic              push_ready;
  logic [20:0]       push_word;

  //////////////////////////////////////////////////////////////////////////////
  // Decode and sequencing
  always_comb begin
    logic       take;
    logic [3:0] cep;
    logic [9:0] words;
    logic [15:0] word;
    logic       can;
    take      = bus.req && !q.ack;   // Ack cycle still shows the old req
    cep       = bus.wdata[3:0];
    words     = '0;
    word      = q.buf_rd ? rx_data : bus.wdata;
    can       = q.buf_rd ? rx_valid : push_ready;
    push      = 1'b0;
    push_word = '0;
    d           = q;
    d.ack       = 1'b0;
    d.validate  = 1'b0;
    d.clear     = 1'b0;
    d.stat_clr  = 1'b0;
    d.dev_reset = 1'b0;
    d.rx_ready  = 1'b0;
    if (take && bus.a0) begin
      // Command phase: upper byte ignored, any new code aborts a phase
      d.ack   = 1'b1;
      d.rdata = '0;
      d.state = UCD_IDLE;
      if (ucd_legal(bus.wdata[7:0], ep_dir_in)) begin
        d.ep     = cep;
        d.act_ep = cep;
        case (bus.wdata[7:4])
          `UCD_GRP_BUF_WR: begin
            d.state  = UCD_BUF_LEN;
            d.buf_rd = 1'b0;
          end
          `UCD_GRP_BUF_RD: begin
            d.state  = UCD_BUF_LEN;
            d.buf_rd = 1'b1;
          end
          `UCD_GRP_STALL:    d.stall[cep] = 1'b1;
          `UCD_GRP_UNSTALL:  d.stall[cep] = 1'b0;
          `UCD_GRP_STATUS:   d.state = UCD_STAT;
          `UCD_GRP_CHECK:    d.state = UCD_CHECK;
          `UCD_GRP_VALIDATE: d.validate = 1'b1;
          `UCD_GRP_CLEAR:    d.clear = 1'b1;
          default: begin
            if (bus.wdata[7:0] == `UCD_CMD_DMA_WR) begin
              d.state = UCD_DMA_WR;
            end else if (bus.wdata[7:0] == `UCD_CMD_DMA_RD) begin
              d.state = UCD_DMA_RD;
            end else begin
              d.dma       = `UCD_DMA_RST;
              d.stall     = `UCD_STALL_RST;
              d.dev_reset = 1'b1;
            end
          end
        endcase
      end
    end else if (take) begin
      // Data phase; a word with no matching command is acked and dropped
      d.rdata = '0;
      d.ack   = 1'b1;
      case (q.state)
        UCD_DMA_WR: begin
          if (bus.wr) begin
            d.dma   = bus.wdata;
            d.state = UCD_IDLE;
          end
        end
        UCD_DMA_RD: begin
          if (!bus.wr) begin
            d.rdata = q.dma;
            d.state = UCD_IDLE;
          end
        end
        UCD_STAT, UCD_CHECK: begin
          if (!bus.wr) begin
            d.rdata    = {8'h00, ep_status[q.ep]};
            d.stat_clr = (q.state == UCD_STAT);
            d.state    = UCD_IDLE;
          end
        end
        UCD_BUF_LEN, UCD_BUF_DATA: begin
          if (bus.wr == !q.buf_rd) begin
            // Stall the bus until the word can move
            d.ack = can;
            if (can) begin
              if (q.state == UCD_BUF_LEN) begin
                // Length word first, then (N+1)/2 words, clamped to the limit
                words  = ucd_words(word, ucd_max_bytes(q.ep, ep_iso[q.ep]));
                d.left = words;
              end else begin
                words  = q.left - 10'h001;
                d.left = words;
              end
              d.state = (words == '0) ? UCD_IDLE : UCD_BUF_DATA;
              if (q.buf_rd) begin
                d.rx_ready = 1'b1;
                d.rdata    = rx_data;
              end else begin
                push      = 1'b1;
                push_word = {words == '0, q.ep, bus.wdata};
              end
            end
          end
        end
        default: d.state = UCD_IDLE;
      endcase
    end
    // Read word stands until the next answer, also through buffer stalls
    if (!d.ack) begin
      d.rdata = q.rdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.state <= UCD_IDLE;
      q.dma   <= `UCD_DMA_RST;
      q.stall <= `UCD_STALL_RST;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outgoing buffer words; a full FIFO holds off the bus answer
  ucd_fifo #(
    .WIDTH (21),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (push_ready),
    .in_data   (push_word),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  ({tx_last, tx_ep, tx_data})
  );

  // Register outputs
  assign bus.ack            = q.ack;
  assign bus.rdata          = q.rdata;
  assign dma_byte_counter   = q.dma;
  assign ep_stall           = q.stall;
  assign validate_pulse     = q.validate;
  assign clear_pulse        = q.clear;
  assign status_clear_pulse = q.stat_clr;
  assign dev_reset_pulse    = q.dev_reset;
  assign act_ep             = q.act_ep;
  assign rx_ready           = q.rx_ready;
  assign rx_ep              = q.ep;
endmodule

/* include/ucd_params.svh */
// Command codes, code groups, limits and reset values of the command decoder
`ifndef UCD_PARAMS_SVH
`define UCD_PARAMS_SVH
// Full command codes
`define UCD_CMD_DMA_WR    8'hF2
`define UCD_CMD_DMA_RD    8'hF3
`define UCD_CMD_RESET     8'hF6
// Code groups, upper nibble; lower nibble is the endpoint index
`define UCD_GRP_BUF_WR    4'h0
`define UCD_GRP_BUF_RD    4'h1
`define UCD_GRP_STALL     4'h4
`define UCD_GRP_STATUS    4'h5
`define UCD_GRP_VALIDATE  4'h6
`define UCD_GRP_CLEAR     4'h7
`define UCD_GRP_UNSTALL   4'h8
`define UCD_GRP_CHECK     4'hD
`define UCD_GRP_GENERAL   4'hF
// Endpoint indices of the control pair
`define UCD_EP_CTRL_OUT   4'h0
`define UCD_EP_CTRL_IN    4'h1
// Buffer length limits in bytes
`define UCD_MAX_SMALL     10'h040
`define UCD_MAX_ISO       10'h3FF
// Reset values
`define UCD_DMA_RST       16'h0000
`define UCD_STALL_RST     16'h0000
// FIFO depth in words
`define UCD_FIFO_DEPTH    16
`endif

/* include/ucd_pkg.sv */
// Types and shared decode functions of the command decoder
`include "ucd_params.svh"
package ucd_pkg;

  typedef enum logic [2:0] {
    UCD_IDLE, UCD_DMA_WR, UCD_DMA_RD, UCD_STAT, UCD_CHECK, UCD_BUF_LEN, UCD_BUF_DATA
  } ucd_state_type;

  typedef enum logic {UCD_H_IDLE, UCD_H_BUSY} ucd_hstate_type;

  //////////////////////////////////////////////////////////////////////////////
  // Legality of a command code against the endpoint directions
  function automatic logic ucd_legal(input logic [7:0] code, input logic [15:0] dir_in);
    logic [3:0] ep;
    logic       in_ep;
    logic       out_ep;
    logic       ok;
    ep     = code[3:0];
    in_ep  = (ep == `UCD_EP_CTRL_IN) || (ep > `UCD_EP_CTRL_IN && dir_in[ep]);
    out_ep = (ep == `UCD_EP_CTRL_OUT) || (ep > `UCD_EP_CTRL_IN && !dir_in[ep]);
    case (code[7:4])
      `UCD_GRP_BUF_WR, `UCD_GRP_VALIDATE: ok = in_ep;
      `UCD_GRP_BUF_RD, `UCD_GRP_CLEAR:    ok = out_ep;
      `UCD_GRP_STALL, `UCD_GRP_STATUS, `UCD_GRP_UNSTALL, `UCD_GRP_CHECK: ok = 1'b1;
      `UCD_GRP_GENERAL: ok = (code == `UCD_CMD_DMA_WR) || (code == `UCD_CMD_DMA_RD)
                             || (code == `UCD_CMD_RESET);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Byte limit of an endpoint buffer
  function automatic logic [9:0] ucd_max_bytes(input logic [3:0] ep, input logic iso);
    return (ep > `UCD_EP_CTRL_IN && iso) ? `UCD_MAX_ISO : `UCD_MAX_SMALL;
  endfunction

  // Words for a byte count, (N + 1) / 2, after clamping to the limit
  function automatic logic [9:0] ucd_words(input logic [15:0] len, input logic [9:0] max);
    logic [9:0]  n;
    logic [10:0] s;
    n = (len > {6'h00, max}) ? max : len[9:0];
    s = {1'b0, n} + 11'h001;
    return s[10:1];
  endfunction

endpackage

/* include/ucd_if.sv */
// Parallel command/data port between processor end and controller end
interface ucd_if (
  input wire logic mclk,
  input wire logic rst
);
  logic        req;    // Held until ack
  logic        a0;     // High: command phase
  logic        wr;     // High: write data phase
  logic [15:0] wdata;
  logic        ack;    // One-cycle answer
  logic [15:0] rdata;

  modport dev (input req, a0, wr, wdata, output ack, rdata);
  modport host (output req, a0, wr, wdata, input ack, rdata);
endinterface

/* core/ucd_host.sv */
// Processor end: issues command and data phases, refuses illegal ones
`include "ucd_params.svh"

module ucd_host (
  input  wire logic        mclk,
  input  wire logic        rst,
  ucd_if.host              bus,
  input  wire logic [15:0] ep_dir_in,
  input  wire logic [15:0] ep_iso,
  input  wire logic        op_valid,
  output logic             op_ready,
  input  wire logic        op_a0,
  input  wire logic        op_wr,
  input  wire logic [15:0] op_wdata,
  output logic             res_valid,
  output logic      [15:0] res_data,
  output logic             op_refused
);
  import ucd_pkg::*;

  typedef struct packed {
    ucd_hstate_type state;
    logic           req;
    logic           a0;
    logic           wr;
    logic [15:0]    wdata;
    logic           ready;
    logic           res_valid;
    logic [15:0]    res_data;
    logic           refused;
    logic           wbuf;
    logic           first;
    logic [3:0]     ep;
    logic [9:0]     left;
  } ucd_host_state_type;

  ucd_host_state_type q;
  ucd_host_state_type d;

  //////////////////////////////////////////////////////////////////////////////
  // One operation at a time; the next waits for the controller's ack
  always_comb begin
    logic       issue;
    logic [9:0] max;
    issue       = 1'b0;
    max         = ucd_max_bytes(q.ep, ep_iso[q.ep]);
    d           = q;
    d.res_valid = 1'b0;
    d.refused   = 1'b0;
    case (q.state)
      UCD_H_IDLE: begin
        d.ready = 1'b1;
        if (op_valid && q.ready) begin
          d.ready = 1'b0;
          if (op_a0) begin
            // Codes 00, 11, 60, 71 and wrong-direction codes never go out
            issue   = ucd_legal(op_wdata[7:0], ep_dir_in);
            d.wbuf  = issue && (op_wdata[7:4] == `UCD_GRP_BUF_WR);
            d.first = 1'b1;
            d.ep    = op_wdata[3:0];
          end else if (op_wr && q.wbuf) begin
            if (q.first) begin
              // Oversized length is refused rather than truncated
              issue  = (op_wdata <= {6'h00, max});
              d.left = ucd_words(op_wdata, max);
              d.first = !issue;
            end else begin
              issue  = (q.left != '0);
              d.left = q.left - 10'h001;
            end
          end else begin
            issue = 1'b1;
          end
          if (issue) begin
            d.req   = 1'b1;
            d.a0    = op_a0;
            d.wr    = op_wr;
            d.wdata = op_wdata;
            d.state = UCD_H_BUSY;
          end else begin
            d.left    = q.left;
            d.refused = 1'b1;
          end
        end
      end
      UCD_H_BUSY: begin
        if (bus.ack) begin
          d.req       = 1'b0;
          d.res_valid = 1'b1;
          d.res_data  = bus.rdata;
          d.state     = UCD_H_IDLE;
        end
      end
      default: d.state = UCD_H_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.state <= UCD_H_IDLE;
    end else begin
      q <= d;
    end
  end

  // Register outputs
  assign bus.req    = q.req;
  assign bus.a0     = q.a0;
  assign bus.wr     = q.wr;
  assign bus.wdata  = q.wdata;
  assign op_ready   = q.ready;
  assign res_valid  = q.res_valid;
  assign res_data   = q.res_data;
  assign op_refused = q.refused;
endmodule

/* tb/ucd_props.sv */
// Protocol checker for the command/data port between the two ends
module ucd_props (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        req,
  input wire logic        a0,
  input wire logic        wr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic        in_buf_q;
  logic        have_len_q;
  logic [16:0] left_q;

  //////////////////////////////////////////////////////////////////////////////
  // Words still owed to a buffer write; first data word is the byte length
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      in_buf_q   <= 1'b0;
      have_len_q <= 1'b0;
      left_q     <= 17'h0_0000;
    end else if (ack && a0) begin
      in_buf_q   <= (wdata[7:4] == 4'h0);
      have_len_q <= 1'b0;
    end else if (ack && wr && in_buf_q) begin
      have_len_q <= 1'b1;
      left_q     <= have_len_q ? left_q - 17'h0_0001 : ({1'b0, wdata} + 17'h0_0001) >> 1;
    end
  end

  sequence s_cmd_issue;
    $rose(req) && a0;
  endsequence

  sequence s_release;
    ack ##1 !req;
  endsequence

  //////////////////////////////////////////////////////////////////////////////
  // Handshake shape, command codes and data phase length
  a_cmd_answer: assert property (s_cmd_issue |=> ack)
    else $error("command phase not answered after one cycle");
  a_ack_release: assert property (ack |-> s_release)
    else $error("request still raised after its answer");
  a_ack_single: assert property (ack |=> !ack)
    else $error("answer longer than one cycle");
  a_ack_needs_req: assert property (ack |-> req)
    else $error("answer without a request");
  a_req_held: assert property (req && !ack |=> req && $stable(a0) && $stable(wr)
                               && $stable(wdata))
    else $error("request changed before its answer");
  a_rdata_hold: assert property ($changed(rdata) |-> ack)
    else $error("read word moved outside an answer");
  a_no_illegal: assert property (req && a0 |->
                                 !(wdata[7:0] inside {8'h00, 8'h11, 8'h60, 8'h71}))
    else $error("forbidden command code on the port");
  a_word_count: assert property (ack && !a0 && wr && in_buf_q && have_len_q
                                 |-> left_q != 17'h0_0000)
    else $error("buffer write longer than its length word");
endmodule

/* tb/testbench.sv */
// Self-checking bench joining the processor end and the controller end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic             mclk, rst, op_valid, op_a0, op_wr, op_ready, res_valid, op_refused, refd;
  logic             validate_pulse, clear_pulse, status_clear_pulse, dev_reset_pulse;
  logic             tx_valid, tx_ready, tx_last, rx_valid, rx_ready;
  logic [15:0]      op_wdata, res_data, ep_dir_in, dma_byte_counter, ep_stall, tx_data, rx_data, r;
  logic [3:0]       act_ep, tx_ep, rx_ep;
  logic [15:0][7:0] ep_status;
  logic [20:0]      txq[$];
  logic [15:0]      rxq[$];
  int               fails, n_tests, n_val, n_clr, n_scl, n_rst, n_ref, i, cyc;

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  ucd_if bus_if (.mclk(mclk), .rst(rst));
  ucd_dev u_ucd_dev (.mclk(mclk), .rst(rst), .bus(bus_if), .ep_dir_in(ep_dir_in),
    .ep_iso(16'h0000), .ep_status(ep_status), .dma_byte_counter(dma_byte_counter),
    .ep_stall(ep_stall), .validate_pulse(validate_pulse), .clear_pulse(clear_pulse),
    .status_clear_pulse(status_clear_pulse), .dev_reset_pulse(dev_reset_pulse),
    .act_ep(act_ep), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .tx_ep(tx_ep), .tx_last(tx_last), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_data(rx_data), .rx_ep(rx_ep));
  ucd_host u_ucd_host (.mclk(mclk), .rst(rst), .bus(bus_if), .ep_dir_in(ep_dir_in),
    .ep_iso(16'h0000), .op_valid(op_valid), .op_ready(op_ready), .op_a0(op_a0),
    .op_wr(op_wr), .op_wdata(op_wdata), .res_valid(res_valid), .res_data(res_data),
    .op_refused(op_refused));
  ucd_props u_ucd_props (.mclk(mclk), .rst(rst), .req(bus_if.req), .a0(bus_if.a0),
    .wr(bus_if.wr), .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata));

  //////////////////////////////////////////////////////////////////////////////
  // Pulse tallies and user streams; slow drain so the FIFO backs up and stalls the bus answer
  always @(posedge mclk) begin
    cyc = cyc + 1;
    tx_ready <= (cyc % 32 == 0);
    if (!rst) begin
      n_val += validate_pulse;
      n_clr += clear_pulse;
      n_scl += status_clear_pulse;
      n_rst += dev_reset_pulse;
      if (tx_valid && tx_ready) txq.push_back({tx_last, tx_ep, tx_data});
      if (rx_ready && rxq.size() > 0) void'(rxq.pop_front());
    end
    // Idle receive line toggles so a stale word is never mistaken for data
    rx_valid <= (rxq.size() != 0);
    rx_data  <= (rxq.size() != 0) ? rxq[0] : ~rx_data;
  end

  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One processor operation; leaves the read word in r and the refusal in refd
  task automatic op(input logic a, input logic w, input logic [15:0] d);
    int k;
    k = 0;
    @(posedge mclk);
    op_valid <= 1'b1;
    op_a0    <= a;
    op_wr    <= w;
    op_wdata <= d;
    do begin
      @(posedge mclk);
      k++;
    end while (op_ready !== 1'b1 && k < 400);
    op_valid <= 1'b0;
    while (res_valid !== 1'b1 && op_refused !== 1'b1 && k < 400) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 400) begin
      fails++;
      test_done();
    end
    r    = res_data;
    refd = op_refused;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    op_valid = 1'b0;
    op_a0 = 1'b0;
    op_wr = 1'b0;
    op_wdata = 16'h0000;
    ep_dir_in = 16'hAAAA;
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data = 16'h0000;
    {fails, n_tests, n_val, n_clr, n_scl, n_rst, cyc} = '0;
    for (i = 0; i < 16; i++) ep_status[i] = 8'h30 + i[7:0];
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    op(1'b1, 1'b0, 16'h00F2);
    op(1'b0, 1'b1, 16'hA5C3);
    check("dma_byte_counter", dma_byte_counter, 16'hA5C3);
    op(1'b1, 1'b0, 16'h00F3);
    op(1'b0, 1'b0, 16'h0000);
    check("dma read", r, 16'hA5C3);
    // Stall every endpoint, reading both status views on the way
    for (i = 0; i < 16; i++) begin
      op(1'b1, 1'b0, {8'h00, 4'h4, i[3:0]});
      check("ep_stall", ep_stall, (24'h00_0002 << i) - 24'h00_0001);
      check("act_ep", act_ep, i[3:0]);
      op(1'b1, 1'b0, {8'h00, 4'h5, i[3:0]});
      op(1'b0, 1'b0, 16'h0000);
      check("status word", r, {8'h00, ep_status[i]});
      op(1'b1, 1'b0, {8'h00, 4'hD, i[3:0]});
      op(1'b0, 1'b0, 16'h0000);
      check("status copy", r, {8'h00, ep_status[i]});
    end
    check("status clears", n_scl, 16);
    for (i = 0; i < 16; i += 2) op(1'b1, 1'b0, {8'h00, 4'h8, i[3:0]});
    check("ep_stall unstalled", ep_stall, 16'hAAAA);
    op(1'b1, 1'b0, 16'h0090);
    check("unlisted code", {ep_stall, 8'h00}, {16'hAAAA, 8'h00});
    check("unlisted dma", dma_byte_counter, 16'hA5C3);
    // Validate and clear on both directions; odd indices are IN
    n_ref = 0;
    for (i = 0; i < 32; i++) begin
      op(1'b1, 1'b0, {8'h00, (i < 16) ? 4'h6 : 4'h7, i[3:0]});
      n_ref += refd;
    end
    check("validate count", n_val, 8);
    check("clear count", n_clr, 8);
    check("refusals", n_ref, 16);
    op(1'b1, 1'b0, 16'h0000);
    check("code 00 refused", refd, 1'b1);
    op(1'b1, 1'b0, 16'h0011);
    check("code 11 refused", refd, 1'b1);
    // Odd length buffer write to an IN endpoint, one word too many
    op(1'b1, 1'b0, 16'h0003);
    op(1'b0, 1'b1, 16'h0027);
    for (i = 0; i < 20; i++) op(1'b0, 1'b1, 16'hB000 + i[15:0]);
    op(1'b0, 1'b1, 16'hBEEF);
    check("extra word refused", refd, 1'b1);
    for (i = 0; i < 1000 && txq.size() < 21; i++) @(posedge mclk);
    check("tx count", txq.size(), 21);
    for (i = 0; i < 21; i++)
      check("tx word", txq[i], {i == 20, 4'h3, (i == 0) ? 16'h0027 : 16'hAFFF + i[15:0]});
    // Buffer read from an OUT endpoint, length word first
    rxq = '{16'h0003, 16'h1122, 16'h3344};
    op(1'b1, 1'b0, 16'h0012);
    op(1'b0, 1'b0, 16'h0000);
    check("read length", r, 16'h0003);
    check("rx_ep", rx_ep, 4'h2);
    op(1'b0, 1'b0, 16'h0000);
    check("read word 1", r, 16'h1122);
    op(1'b0, 1'b0, 16'h0000);
    check("read word 2", r, 16'h3344);
    op(1'b1, 1'b0, 16'h00F6);
    check("reset stall", ep_stall, 16'h0000);
    check("reset dma", dma_byte_counter, 16'h0000);
    check("reset pulse", n_rst, 1);
    test_done();
  end
endmodule
